// >>> hdl/windowed_watchdog.sv
// Summary of operation
// - A counter clear while the count sits in the second half of the timeout fires reset at the next watchdog tick.
// - A write to timeout select, ban select, enable or mode starts a sync into the watchdog domain.
// - Only the enable bit shows its synchronized state; the other fields give no completion sign.
// - The enable bit reads back its synchronized state so software can poll it after a change.
`timescale 1ns/100ps
`default_nettype none
module windowed_watchdog
  import wdog_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic wdog_tick_i,
  input wire logic [wdog_pkg::ADDR_W-1:0] addr_i,
  input wire logic [wdog_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [wdog_pkg::DATA_W-1:0] rdata_o,
  output logic sync_busy_o,
  output logic wdog_reset_o
);
  import wdog_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Bus side holds the written fields; wdog side applies them after the
  // toggle crosses two stages of the watchdog tick.

  typedef struct packed {
    logic en;
    logic mode;
    logic [SEL_W-1:0] psel;
    logic [SEL_W-1:0] ban;
    logic req_tgl;
    logic [SYNC_STAGES-1:0] ack_sync;
    logic [SYNC_STAGES-1:0] req_sync;
    logic ack_tgl;
    logic w_en;
    logic w_mode;
    logic [SEL_W-1:0] w_psel;
    logic [SEL_W-1:0] w_ban;
    logic [CNT_W-1:0] count;
    logic clr_pend;
    logic rst;
    logic [DATA_W-1:0] rdata;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  function automatic logic [CNT_W-1:0] limit_of(input logic [SEL_W-1:0] sel);
    limit_of = CNT_W'(1) << sel;
  endfunction : limit_of

  logic busy;
  logic [CNT_W-1:0] limit;
  assign busy = st_r.req_tgl != st_r.ack_sync[SYNC_STAGES-1];
  assign limit = limit_of(st_r.w_psel);

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    st_nxt = st_r;
    st_nxt.ack_sync = {st_r.ack_sync[SYNC_STAGES-2:0], st_r.ack_tgl};
    st_nxt.rdata = '0;
    if (wr_i && addr_i == OFS_CTRL) begin
      st_nxt.en = wdata_i[CTRL_EN_BIT];
      st_nxt.mode = wdata_i[CTRL_MODE_BIT];
      st_nxt.psel = wdata_i[CTRL_PSEL_LSB +: SEL_W];
      st_nxt.ban = wdata_i[CTRL_BAN_LSB +: SEL_W];
      st_nxt.req_tgl = ~st_r.req_tgl;
    end
    // A clear is held until the next watchdog tick so no clear is lost.
    if (wr_i && addr_i == OFS_CLEAR && wdata_i == CLEAR_KEY) begin
      st_nxt.clr_pend = 1'b1;
    end
    if (rd_i) begin
      unique case (addr_i)
        OFS_CTRL: begin
          st_nxt.rdata[CTRL_EN_BIT] = st_r.w_en;
          st_nxt.rdata[CTRL_MODE_BIT] = st_r.mode;
          st_nxt.rdata[CTRL_PSEL_LSB +: SEL_W] = st_r.psel;
          st_nxt.rdata[CTRL_BAN_LSB +: SEL_W] = st_r.ban;
        end
        OFS_STATUS: st_nxt.rdata = {30'h0, st_r.rst, busy};
        OFS_COUNT: st_nxt.rdata = st_r.count;
        default: st_nxt.rdata = '0;
      endcase
    end
    if (wdog_tick_i) begin
      st_nxt.req_sync = {st_r.req_sync[SYNC_STAGES-2:0], st_r.req_tgl};
      if (st_r.req_sync[SYNC_STAGES-1] != st_r.ack_tgl) begin
        st_nxt.w_en = st_r.en;
        st_nxt.w_mode = st_r.mode;
        st_nxt.w_psel = st_r.psel;
        st_nxt.w_ban = st_r.ban;
        st_nxt.ack_tgl = st_r.req_sync[SYNC_STAGES-1];
      end
      if (st_r.w_en && !st_r.rst) begin
        if (st_r.clr_pend) begin
          // Clearing late in the period trips reset; kept for compatibility.
          if (st_r.count >= (limit >> 1)) begin
            st_nxt.rst = 1'b1;
          end else begin
            st_nxt.count = '0;
          end
        end else if (st_r.count >= limit - CNT_W'(1)) begin
          st_nxt.rst = 1'b1;
        end else begin
          st_nxt.count = st_r.count + CNT_W'(1);
        end
      end else if (!st_r.w_en) begin
        st_nxt.count = '0;
      end
      st_nxt.clr_pend = 1'b0;
      if (wr_i && addr_i == OFS_CLEAR && wdata_i == CLEAR_KEY) begin
        st_nxt.clr_pend = 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r <= '{en: 1'b0, mode: 1'b0, psel: PSEL_RESET, ban: BAN_RESET, req_tgl: 1'b0,
                ack_sync: '0, req_sync: '0, ack_tgl: 1'b0, w_en: 1'b0, w_mode: 1'b0,
                w_psel: PSEL_RESET, w_ban: BAN_RESET, count: '0, clr_pend: 1'b0,
                rst: 1'b0, rdata: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata_o = st_r.rdata;
  assign sync_busy_o = busy;
  assign wdog_reset_o = st_r.rst;
endmodule : windowed_watchdog
`default_nettype wire

// >>> include/wdog_pkg.sv
package wdog_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_CLEAR = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 4'hc;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_MODE_BIT = 1;
  localparam int CTRL_PSEL_LSB = 8;
  localparam int CTRL_BAN_LSB = 16;
  localparam int SEL_W = 5;
  localparam logic [31:0] CLEAR_KEY = 32'h0000_00a5;
  localparam logic [SEL_W-1:0] PSEL_RESET = 5'h10;
  localparam logic [SEL_W-1:0] BAN_RESET = 5'h0f;
  localparam int CNT_W = 32;
  localparam int SYNC_STAGES = 2;
endpackage : wdog_pkg

// >>> testbench/wdog_chk_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module wdog_chk
  import wdog_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic sync_busy_o,
  input wire logic wdog_reset_o,
  input wire logic [wdog_pkg::ADDR_W-1:0] addr_i,
  input wire logic [wdog_pkg::DATA_W-1:0] rdata_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  sync_go_a: assert property (wr_i && addr_i == OFS_CTRL |=> sync_busy_o)
    else $error("sync not started");
  busy_why_a: assert property ($rose(sync_busy_o) |-> $past(wr_i) && $past(addr_i) == OFS_CTRL)
    else $error("busy without write");
  busy_bit_a: assert property (rd_i && addr_i == OFS_STATUS |=>
    rdata_o[0] == $past(sync_busy_o)) else $error("busy bit wrong");
  reset_hold_a: assert property (wdog_reset_o |=> wdog_reset_o)
    else $error("reset dropped");
  rdata_idle_a: assert property (!rd_i |=> rdata_o == '0)
    else $error("read data not idle");
  cover property (sync_busy_o ##1 !sync_busy_o);
  cover property ($rose(wdog_reset_o));
  cover property (wr_i && addr_i == OFS_CLEAR);
endmodule : wdog_chk
////////////////////////////////////////////////////////////////////////////////
bind windowed_watchdog wdog_chk chk_u (.clock_i(clock_i), .reset_n_i(reset_n_i), .wr_i(wr_i),
  .rd_i(rd_i), .sync_busy_o(sync_busy_o), .wdog_reset_o(wdog_reset_o), .addr_i(addr_i),
  .rdata_o(rdata_o));
`default_nettype wire

// >>> testbench/windowed_watchdog_sync_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; \
  $display("mismatch %0t %h %h", $time, a, b); end end
module windowed_watchdog_sync_control_tb;
  import wdog_pkg::*;
  logic clock_i = 0, reset_n_i = 0, wr_i = 0, rd_i = 0, sync_busy_o, wdog_reset_o;
  logic [1:0] tc = 0;
  logic [ADDR_W-1:0] addr_i = 0;
  logic [DATA_W-1:0] wdata_i = 0, rdata_o, d;
  int fails = 0, tests_run = 0, i;
  always #5 clock_i = ~clock_i;
  // A tick on every fourth clock keeps the watchdog rate well apart from the bus rate.
  always @(posedge clock_i) tc <= tc + 1;
  windowed_watchdog dut_u (.clock_i, .reset_n_i, .wdog_tick_i(tc == 2'h3), .addr_i, .wdata_i,
    .wr_i, .rd_i, .rdata_o, .sync_busy_o, .wdog_reset_o);
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge clock_i);
    addr_i <= a; wdata_i <= v; wr_i <= 1;
    @(posedge clock_i) wr_i <= 0;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge clock_i);
    addr_i <= a; rd_i <= 1;
    @(posedge clock_i) rd_i <= 0;
    #1 d = rdata_o;
  endtask : rd
  task automatic start(input logic [SEL_W-1:0] p);
    reset_n_i <= 0;
    repeat (16) @(posedge clock_i);
    reset_n_i <= 1;
    wr(OFS_CTRL, (DATA_W'(p) << CTRL_PSEL_LSB) | 32'h1);
    #1 `CHK(sync_busy_o, 1'b1)
    rd(OFS_STATUS);
    `CHK(d[0], 1'b1)
    rd(OFS_CTRL);
    `CHK(d[0], 1'b0)
    `CHK(d[CTRL_PSEL_LSB +: SEL_W], p)
    // No further control write until the enable readback settles.
    for (i = 0; i < 60 && !d[0]; i++) rd(OFS_CTRL);
    `CHK(d[0], 1'b1)
    `CHK(wdog_reset_o, 1'b0)
  endtask : start
  task automatic t_timeout();
    start(5'h3);
    for (i = 0; i < 200 && !wdog_reset_o; i++) @(posedge clock_i);
    `CHK(wdog_reset_o, 1'b1)
    rd(OFS_STATUS);
    `CHK(d[1], 1'b1)
    $display("timeout test done");
  endtask : t_timeout
  task automatic t_clear(input int n, input logic e);
    start(5'h4);
    d = 0;
    for (i = 0; i < 100 && d < n; i++) rd(OFS_COUNT);
    wr(OFS_CLEAR, CLEAR_KEY);
    repeat (6) @(posedge clock_i);
    `CHK(wdog_reset_o, e)
    $display("clear test done");
  endtask : t_clear
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  initial begin
    t_timeout();
    t_clear(2, 1'b0);
    t_clear(9, 1'b1);
    end_of_test();
  end
  initial begin
    #50000;
    fails++;
    end_of_test();
  end
endmodule : windowed_watchdog_sync_control_tb
`default_nettype wire
